// *** src/supervisor_cfg.svh ***
// offsets, bit positions, reset values and timing counts of the supervisor
//
// Notes on behaviour
// - pin follows level bit when modes off
// - level and test bits zero pull low
// - shared pin only pulls low, else released
// - test battery at power-up and daily
// - low test result sets battery-low flag
// - flag stays until a later test passes
// - tests only while main supply present
// - recovery-time select bit in clock reg
// - select and stop bits pick deselect time
// - first power-up clears listed bits, watchdog
// - first power-up sets stop, level, halt
// - later power-up keeps some, clears others, sets halt
// - watchdog pin use beats frequency test
// - flags register read clears watchdog flag
`ifndef SUPERVISOR_CFG_SVH
`define SUPERVISOR_CFG_SVH

// register indexes, byte address is four times the index
`define REG_STOP_IDX 5'h01
`define REG_CLOCK_IDX 5'h04
`define REG_CTRL_IDX 5'h08
`define REG_WDOG_IDX 5'h09
`define REG_ALARM_IDX 5'h0A
`define REG_HALT_IDX 5'h0C
`define REG_FLAGS_IDX 5'h0F
`define REG_IRQ_STAT_IDX 5'h10
`define REG_IRQ_MASK_IDX 5'h11
`define REG_STATE_IDX 5'h12

// field positions
`define STOP_BIT 7
`define TR_BIT 7
`define OUT_BIT 7
`define FT_BIT 6
`define WDS_BIT 7
`define AFE_BIT 7
`define SQUARE_WAVE_ENABLE_BIT 6
`define ABE_BIT 5
`define HT_BIT 6
`define WDF_BIT 7
`define BL_BIT 4

// interrupt event positions
`define EV_BATT_LOW 0
`define EV_WDOG 1
`define EV_RECOVERED 2
`define EV_COUNT 3

// reset values
`define WDOG_INIT 8'h00
`define IRQ_MASK_INIT 3'h0

// timing
`define CLK_FREQ_HZ 200000000
`define OSC_FREQ_HZ 32768
`define BATT_INTERVAL_S 86400
`define TREC_TR0_ST0_US 96000
`define TREC_TR0_ST1_US 40000
`define TREC_TR1_US 50
`define OSC_DIV_CYCLES (`CLK_FREQ_HZ / `OSC_FREQ_HZ)
`define US_TO_OSC_TICKS(us) \
  ((64'(us) * 64'(`OSC_FREQ_HZ) + 64'd999999) / 64'd1000000)
`define BATT_INTERVAL_TICKS (64'(`BATT_INTERVAL_S) * 64'(`OSC_FREQ_HZ))

`endif

// *** src/supervisor_pkg.sv ***
// types shared by the supervisor files
package supervisor_pkg;

  // power sequencing states, one-hot
  typedef enum logic [2:0] {
    PWR_BACKUP = 3'b001,
    PWR_RECOVER = 3'b010,
    PWR_RUN = 3'b100
  } power_state_type;

  typedef logic [11:0] osc_ticks_type;

endpackage

// *** src/osc_timer_if.sv ***
// link between the supervisor control and its oscillator-domain timer
`timescale 1ns/1ps
`default_nettype none
interface osc_timer_if;
  logic start;
  logic run_enable;
  supervisor_pkg::osc_ticks_type recover_ticks;
  logic recover_busy;
  logic interval_due;

  modport ctrl (output start, output run_enable, output recover_ticks,
                input recover_busy, input interval_due);
  modport timer (input start, input run_enable, input recover_ticks,
                 output recover_busy, output interval_due);
endinterface
`default_nettype wire

// *** src/osc_timer.sv ***
// oscillator tick prescaler, recovery counter and battery test interval
`timescale 1ns/1ps
`default_nettype none
module osc_timer #(
  parameter int unsigned OSC_DIV = 6103,
  parameter int unsigned INTERVAL_TICKS = 32'd2831155200
) (
  input wire logic clk,
  input wire logic srst,
  osc_timer_if.timer t
);
  logic [15:0] div_r;
  logic [11:0] recover_r;
  logic [31:0] interval_r;
  logic osc_tick;
  logic interval_end;

  // one clock pulse per oscillator period
  assign osc_tick = (div_r == 16'(OSC_DIV - 1));
  assign interval_end = osc_tick && (interval_r == 32'(INTERVAL_TICKS - 1));
  assign t.recover_busy = (recover_r != 12'h000);
  assign t.interval_due = interval_end;

  // prescaler restarts with each power-up so periods line up
  always_ff @(posedge clk) begin
    if (srst || t.start || osc_tick) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  // deselect recovery countdown in oscillator ticks
  always_ff @(posedge clk) begin
    if (srst) begin
      recover_r <= 12'h000;
    end else if (t.start) begin
      recover_r <= t.recover_ticks;
    end else if (osc_tick && t.recover_busy) begin
      recover_r <= recover_r - 12'h001;
    end
  end

  // daily interval counts only while main supply is up
  always_ff @(posedge clk) begin
    if (srst || t.start || !t.run_enable || interval_end) begin
      interval_r <= 32'h0000_0000;
    end else if (osc_tick) begin
      interval_r <= interval_r + 32'h0000_0001;
    end
  end
endmodule
`default_nettype wire

// *** src/supervisor_defaults_battery_monitor.sv ***
// supervisor control: shared pin, battery monitor, recovery, defaults
//
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "supervisor_cfg.svh"
`default_nettype none
module supervisor_defaults_battery_monitor #(
  parameter int unsigned OSC_DIV = `OSC_DIV_CYCLES,
  parameter int unsigned INTERVAL_TICKS = 32'(`BATT_INTERVAL_TICKS)
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic supply_above_threshold,
  input wire logic first_battery_attach,
  input wire logic battery_below_low,
  input wire logic watchdog_timeout,
  input wire logic watchdog_pin_request,
  input wire logic alarm_irq_request,
  input wire logic frequency_test_wave,
  input wire logic shared_open_drain_pin_i,
  output logic shared_open_drain_pin_o,
  output logic shared_open_drain_pin_oe,
  output logic write_deselect,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic resp_r;
  logic [31:0] readdata_r;
  logic [31:0] read_mux;
  logic supply_prev_r;
  supervisor_pkg::power_state_type state_r;
  supervisor_pkg::power_state_type state_nxt;
  logic oscillator_stop_bit_r;
  logic recovery_time_select_r;
  logic level_out_bit_r;
  logic frequency_test_bit_r;
  logic [7:0] watchdog_r;
  logic alarm_flag_enable_r;
  logic square_wave_enable_r;
  logic alarm_in_backup_enable_r;
  logic halt_update_bit_r;
  logic watchdog_flag_r;
  logic battery_low_flag_r;
  logic [`EV_COUNT-1:0] irq_stat_r;
  logic [`EV_COUNT-1:0] irq_mask_r;
  logic [`EV_COUNT-1:0] irq_event;
  logic pin_pull_r;

  logic request;
  logic rd_acc;
  logic wr_acc;
  logic hit_stop;
  logic hit_clock;
  logic hit_ctrl;
  logic hit_wdog;
  logic hit_alarm;
  logic hit_halt;
  logic hit_flags;
  logic hit_irq_stat;
  logic hit_irq_mask;
  logic hit_state;
  logic power_up;
  logic battery_test;
  logic recover_done;
  logic [7:0] wbyte;
  logic be0;
  logic wdog_on_pin;
  logic pull_low_nxt;

  osc_timer_if tif ();

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // byte-lane merge of the low lane into a stored byte
  function automatic logic [7:0] merge_low(input logic [7:0] old_v,
                                           input logic [7:0] new_v,
                                           input logic lane);
    merge_low = lane ? new_v : old_v;
  endfunction

  // byte-lane merge of a single stored bit
  function automatic logic merge_bit(input logic old_v, input logic new_v,
                                     input logic lane);
    merge_bit = lane ? new_v : old_v;
  endfunction

  // recovery time from select and stop bits
  function automatic supervisor_pkg::osc_ticks_type trec_ticks(
      input logic tr, input logic st);
    if (tr) begin
      trec_ticks = 12'(`US_TO_OSC_TICKS(`TREC_TR1_US));
    end else if (st) begin
      trec_ticks = 12'(`US_TO_OSC_TICKS(`TREC_TR0_ST1_US));
    end else begin
      trec_ticks = 12'(`US_TO_OSC_TICKS(`TREC_TR0_ST0_US));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then the answer

  assign request = avs_read || avs_write;
  assign avs_waitrequest = request && !resp_r;
  assign rd_acc = avs_read && resp_r;
  // writes are dropped while the device is deselected
  assign wr_acc = avs_write && resp_r && !write_deselect;
  assign wbyte = avs_writedata[7:0];
  assign be0 = avs_byteenable[0];
  assign avs_readdata = readdata_r;

  // address decode
  assign hit_stop = (avs_address == `REG_STOP_IDX);
  assign hit_clock = (avs_address == `REG_CLOCK_IDX);
  assign hit_ctrl = (avs_address == `REG_CTRL_IDX);
  assign hit_wdog = (avs_address == `REG_WDOG_IDX);
  assign hit_alarm = (avs_address == `REG_ALARM_IDX);
  assign hit_halt = (avs_address == `REG_HALT_IDX);
  assign hit_flags = (avs_address == `REG_FLAGS_IDX);
  assign hit_irq_stat = (avs_address == `REG_IRQ_STAT_IDX);
  assign hit_irq_mask = (avs_address == `REG_IRQ_MASK_IDX);
  assign hit_state = (avs_address == `REG_STATE_IDX);

  // answer flag toggles so each request sees exactly one wait cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      resp_r <= 1'b0;
    end else begin
      resp_r <= request && !resp_r;
    end
  end

  // read mux, unmapped indexes read as zero
  always_comb begin
    read_mux = 32'h0000_0000;
    if (hit_stop) begin
      read_mux[`STOP_BIT] = oscillator_stop_bit_r;
    end else if (hit_clock) begin
      read_mux[`TR_BIT] = recovery_time_select_r;
    end else if (hit_ctrl) begin
      read_mux[`OUT_BIT] = level_out_bit_r;
      read_mux[`FT_BIT] = frequency_test_bit_r;
    end else if (hit_wdog) begin
      read_mux[7:0] = watchdog_r;
    end else if (hit_alarm) begin
      read_mux[`AFE_BIT] = alarm_flag_enable_r;
      read_mux[`SQUARE_WAVE_ENABLE_BIT] = square_wave_enable_r;
      read_mux[`ABE_BIT] = alarm_in_backup_enable_r;
    end else if (hit_halt) begin
      read_mux[`HT_BIT] = halt_update_bit_r;
    end else if (hit_flags) begin
      read_mux[`WDF_BIT] = watchdog_flag_r;
      read_mux[`BL_BIT] = battery_low_flag_r;
    end else if (hit_irq_stat) begin
      read_mux[`EV_COUNT-1:0] = irq_stat_r;
    end else if (hit_irq_mask) begin
      read_mux[`EV_COUNT-1:0] = irq_mask_r;
    end else if (hit_state) begin
      read_mux[2:0] = state_r;
      read_mux[3] = shared_open_drain_pin_i;
      read_mux[4] = tif.recover_busy;
    end
  end

  // read data captured in the wait cycle, stands in the answer cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      readdata_r <= 32'h0000_0000;
    end else if (avs_read && !resp_r) begin
      readdata_r <= read_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power sequencing and recovery timing

  assign power_up = supply_above_threshold && !supply_prev_r;
  assign recover_done = (state_r == supervisor_pkg::PWR_RECOVER) &&
                        !tif.recover_busy;
  assign write_deselect = (state_r != supervisor_pkg::PWR_RUN);

  // timer start uses the bits as they stand after the defaults
  assign tif.start = power_up;
  assign tif.run_enable = supply_above_threshold;
  assign tif.recover_ticks = first_battery_attach ?
      trec_ticks(1'b0, 1'b1) :
      trec_ticks(recovery_time_select_r, oscillator_stop_bit_r);

  // next power state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      supervisor_pkg::PWR_BACKUP: begin
        if (power_up) begin
          state_nxt = supervisor_pkg::PWR_RECOVER;
        end
      end
      supervisor_pkg::PWR_RECOVER: begin
        if (!supply_above_threshold) begin
          state_nxt = supervisor_pkg::PWR_BACKUP;
        end else if (!tif.recover_busy) begin
          state_nxt = supervisor_pkg::PWR_RUN;
        end
      end
      supervisor_pkg::PWR_RUN: begin
        if (!supply_above_threshold) begin
          state_nxt = supervisor_pkg::PWR_BACKUP;
        end
      end
      default: begin
        state_nxt = supervisor_pkg::PWR_BACKUP;
      end
    endcase
  end

  // power state and supply edge tracking
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= supervisor_pkg::PWR_BACKUP;
      supply_prev_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      supply_prev_r <= supply_above_threshold;
    end
  end

  osc_timer #(
    .OSC_DIV(OSC_DIV),
    .INTERVAL_TICKS(INTERVAL_TICKS)
  ) u_osc_timer (
    .clk(clk),
    .srst(srst),
    .t(tif.timer)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control bits with power-up defaults

  // bits kept over a later power-up; on first attach stop and level are set, select is cleared
  always_ff @(posedge clk) begin
    if (srst) begin
      recovery_time_select_r <= 1'b0;
      oscillator_stop_bit_r <= 1'b1;
      level_out_bit_r <= 1'b1;
    end else if (power_up && first_battery_attach) begin
      recovery_time_select_r <= 1'b0;
      oscillator_stop_bit_r <= 1'b1;
      level_out_bit_r <= 1'b1;
    end else if (wr_acc) begin
      if (hit_clock) begin
        recovery_time_select_r <= merge_bit(recovery_time_select_r,
                                            wbyte[`TR_BIT], be0);
      end
      if (hit_stop) begin
        oscillator_stop_bit_r <= merge_bit(oscillator_stop_bit_r,
                                           wbyte[`STOP_BIT], be0);
      end
      if (hit_ctrl) begin
        level_out_bit_r <= merge_bit(level_out_bit_r,
                                     wbyte[`OUT_BIT], be0);
      end
    end
  end

  // bits cleared or set on every power-up
  always_ff @(posedge clk) begin
    if (srst || power_up) begin
      frequency_test_bit_r <= 1'b0;
      watchdog_r <= `WDOG_INIT;
      alarm_flag_enable_r <= 1'b0;
      square_wave_enable_r <= 1'b0;
      alarm_in_backup_enable_r <= 1'b0;
      halt_update_bit_r <= 1'b1;
    end else if (wr_acc) begin
      if (hit_ctrl) begin
        frequency_test_bit_r <= merge_bit(frequency_test_bit_r,
                                          wbyte[`FT_BIT], be0);
      end
      if (hit_wdog) begin
        watchdog_r <= merge_low(watchdog_r, wbyte, be0);
      end
      if (hit_alarm && be0) begin
        alarm_flag_enable_r <= wbyte[`AFE_BIT];
        square_wave_enable_r <= wbyte[`SQUARE_WAVE_ENABLE_BIT];
        alarm_in_backup_enable_r <= wbyte[`ABE_BIT];
      end
      if (hit_halt && be0) begin
        halt_update_bit_r <= wbyte[`HT_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // battery monitor and flags

  // test at power-up and each interval, only on main supply
  assign battery_test = supply_above_threshold &&
                        (power_up || tif.interval_due);

  // flag follows each test result and holds between tests
  always_ff @(posedge clk) begin
    if (srst) begin
      battery_low_flag_r <= 1'b0;
    end else if (battery_test) begin
      battery_low_flag_r <= battery_below_low;
    end
  end

  // watchdog flag, a timeout in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (srst) begin
      watchdog_flag_r <= 1'b0;
    end else if (watchdog_timeout) begin
      watchdog_flag_r <= 1'b1;
    end else if (rd_acc && hit_flags) begin
      watchdog_flag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  assign irq_event[`EV_BATT_LOW] = battery_test && battery_below_low;
  assign irq_event[`EV_WDOG] = watchdog_timeout;
  assign irq_event[`EV_RECOVERED] = recover_done;
  assign irq = |(irq_stat_r & irq_mask_r);

  // sticky event bits, read clears, a new event wins
  for (genvar i = 0; i < `EV_COUNT; i++) begin : g_irq
    always_ff @(posedge clk) begin
      if (srst) begin
        irq_stat_r[i] <= 1'b0;
      end else if (irq_event[i]) begin
        irq_stat_r[i] <= 1'b1;
      end else if (rd_acc && hit_irq_stat) begin
        irq_stat_r[i] <= 1'b0;
      end
    end
  end

  // interrupt mask
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_mask_r <= `IRQ_MASK_INIT;
    end else if (wr_acc && hit_irq_mask && be0) begin
      irq_mask_r <= wbyte[`EV_COUNT-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared open-drain pin

  // watchdog steered to the pin owns it over test and level use
  assign wdog_on_pin = (watchdog_r != 8'h00) && !watchdog_r[`WDS_BIT];

  // pull-down select by priority of pin uses
  always_comb begin
    if (wdog_on_pin) begin
      pull_low_nxt = watchdog_pin_request;
    end else if (watchdog_r != 8'h00) begin
      pull_low_nxt = 1'b0;
    end else if (frequency_test_bit_r) begin
      pull_low_nxt = !frequency_test_wave;
    end else if (alarm_flag_enable_r) begin
      pull_low_nxt = alarm_irq_request;
    end else begin
      pull_low_nxt = !level_out_bit_r;
    end
  end

  // registered pull-down, pin never driven high
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_pull_r <= 1'b0;
    end else begin
      pin_pull_r <= pull_low_nxt;
    end
  end

  assign shared_open_drain_pin_o = 1'b0;
  assign shared_open_drain_pin_oe = pin_pull_r;

endmodule
`default_nettype wire

// *** testbench/supervisor_chk.sv ***
// port assertions for the supervisor block
`timescale 1ns/1ps
`default_nettype none
module supervisor_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic supply_above_threshold,
  input wire logic battery_below_low,
  input wire logic watchdog_timeout,
  input wire logic shared_open_drain_pin_o,
  input wire logic write_deselect,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic req;
  logic rd_ok;
  // bus request and accepted status read
  assign req = avs_read | avs_write;
  assign rd_ok = avs_read & !avs_waitrequest & (avs_address == 5'h10);
  ////////////////////////////////////////////////////////////////////////
  // power-up sequences and port properties
  sequence s_up;
    $rose(supply_above_threshold);
  endsequence
  sequence s_hold;
    write_deselect [*4];
  endsequence
  property p_od;
    shared_open_drain_pin_o == 1'b0;
  endproperty
  property p_wait;
    $rose(req) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  property p_idle;
    !req |-> !avs_waitrequest;
  endproperty
  property p_hi;
    avs_readdata[31:8] == 24'h000000;
  endproperty
  property p_stand;
    !avs_read |=> $stable(avs_readdata);
  endproperty
  property p_drop;
    !supply_above_threshold |=> write_deselect;
  endproperty
  property p_rec;
    s_up |=> s_hold;
  endproperty
  property p_clr;
    rd_ok && !watchdog_timeout && !battery_below_low && !write_deselect
      |=> !irq;
  endproperty
  property p_src;
    $rose(irq) |-> $past(watchdog_timeout) || $past(avs_write) ||
      $past(battery_below_low) || $past(write_deselect);
  endproperty
  ////////////////////////////////////////////////////////////////////////
  a_od: assert property (p_od) else $error("pin drives high");
  a_wait: assert property (p_wait) else $error("wait cycle wrong");
  a_idle: assert property (p_idle) else $error("wait while idle");
  a_hi: assert property (p_hi) else $error("upper read bits set");
  a_stand: assert property (p_stand) else $error("read data moved");
  a_drop: assert property (p_drop) else $error("no deselect");
  a_rec: assert property (p_rec) else $error("recovery short");
  a_clr: assert property (p_clr) else $error("irq kept");
  a_src: assert property (p_src) else $error("irq from nothing");
endmodule
`default_nettype wire

// *** testbench/host_model.sv ***
// host processor model driving the register bus
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk,
  output logic [4:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  // bus idle at time zero
  initial begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
  end
  // one transfer, held until waitrequest is seen low
  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_read <= !w;
    avs_write <= w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~avs_writedata;
  endtask
endmodule
`default_nettype wire

// *** testbench/supervisor_defaults_battery_monitor_bench.sv ***
// self-checking bench for the supervisor block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  mismatches++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module supervisor_defaults_battery_monitor_bench;
  localparam int unsigned DIV = 4;
  localparam int unsigned IVL = 20;
  logic clk, srst, sup, first, blow, wdt, wdreq, wave, pin, alrq;
  logic [4:0] addr;
  logic rd_s, wr_s, wreq, oe, pin_o, des, irq_w;
  logic [31:0] wdat, rdat;
  logic [3:0] be;
  logic [7:0] q;
  int m[32];
  int mismatches, n_tests, t, i, j;
  // pulled-up shared line
  assign pin = (oe === 1'b1) ? pin_o : 1'b1;
  supervisor_defaults_battery_monitor #(.OSC_DIV(DIV),
    .INTERVAL_TICKS(IVL)) DUT (.clk(clk), .srst(srst),
    .avs_address(addr), .avs_read(rd_s), .avs_write(wr_s),
    .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .supply_above_threshold(sup),
    .first_battery_attach(first), .battery_below_low(blow),
    .watchdog_timeout(wdt), .watchdog_pin_request(wdreq),
    .alarm_irq_request(alrq), .frequency_test_wave(wave),
    .shared_open_drain_pin_i(pin), .shared_open_drain_pin_o(pin_o),
    .shared_open_drain_pin_oe(oe), .write_deselect(des), .irq(irq_w));
  host_model host (.clk(clk), .avs_address(addr), .avs_read(rd_s),
    .avs_write(wr_s), .avs_writedata(wdat), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(wreq));
  ////////////////////////////////////////////////////////////////////////
  // bus helpers; the model keeps only writes made outside deselect
  task automatic rd(input logic [4:0] a);
    host.xfer(1'b0, a, 8'h00, q);
  endtask
  // deselect judged at the accept edge, as the design sees it
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, q);
    if (des === 1'b0)
      m[a] = d;
  endtask
  // raise supply, apply defaults to the model, time the deselect
  task automatic power_up(input logic fa, input int ticks);
    @(posedge clk);
    first <= fa;
    sup <= 1'b1;
    m[9] = 0;
    m[10] = 0;
    m[12] = 8'h40;
    m[8] = fa ? 8'h80 : (m[8] & 8'h80);
    m[1] = fa ? 8'h80 : m[1];
    m[4] = fa ? 0 : m[4];
    t = 0;
    @(posedge clk);
    while (des !== 1'b0 && t < 20000) begin
      @(posedge clk);
      t++;
    end
    `CHK("recovery", 1'b1, t >= ticks * DIV && t <= ticks * DIV + 3)
    rd(5'h01);
    `CHK("stop", m[1] & 8'h80, q & 8'h80)
    rd(5'h04);
    `CHK("select", m[4] & 8'h80, q & 8'h80)
    rd(5'h08);
    `CHK("control", m[8] & 8'hC0, q & 8'hC0)
    rd(5'h09);
    `CHK("watchdog", 8'h00, q)
    rd(5'h0A);
    `CHK("alarm", 8'h00, q & 8'hE0)
    rd(5'h0C);
    `CHK("halt", 8'h40, q & 8'h40)
    rd(5'h0F);
    `CHK("batt low", blow, q[4])
  endtask
  // verdict
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #400000;
    mismatches++;
    final_report();
  end
  // main sequence
  initial begin
    srst = 1'b1;
    sup = 1'b0;
    first = 1'b1;
    blow = 1'b1;
    wdt = 1'b0;
    wdreq = 1'b0;
    wave = 1'b0;
    alrq = 1'b0;
    mismatches = 0;
    n_tests = 0;
    t = $urandom(32'h5FBF);
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    `CHK("deselect", 1'b1, des)
    power_up(1'b1, 1311);
    if (q[4] === 1'b1) begin
      rd(5'h01);
      `CHK("stop again", 8'h80, q & 8'h80)
    end
    rd(5'h10);
    `CHK("status", 8'h05, q & 8'h07)
    $display("test first attach done");
    for (i = 0; i < 4; i++) begin
      wr(5'h08, {i[1], i[0], 6'h00});
      for (j = 0; j < 3; j++) begin
        wave <= 1'($urandom);
        repeat (3) @(posedge clk);
        `CHK("pin", i[0] ? !wave : !i[1], oe)
      end
    end
    wr(5'h09, 8'h0E);
    for (j = 0; j < 4; j++) begin
      wdreq <= 1'($urandom);
      repeat (3) @(posedge clk);
      `CHK("wd pin", wdreq, oe)
    end
    wr(5'h09, 8'h8E);
    repeat (3) @(posedge clk);
    `CHK("wd steer", 1'b0, oe)
    wr(5'h09, 8'h00);
    wr(5'h08, 8'h80);
    wr(5'h0A, 8'h80);
    for (j = 0; j < 3; j++) begin
      alrq <= 1'($urandom);
      repeat (3) @(posedge clk);
      `CHK("alarm pin", alrq, oe)
    end
    wr(5'h0A, 8'h00);
    $display("test pin done");
    wr(5'h11, 8'h02);
    wdt <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b1, irq_w)
    rd(5'h0F);
    `CHK("wd flag", 1'b1, q[7])
    rd(5'h0F);
    `CHK("wd flag clr", 1'b0, q[7])
    blow <= 1'b0;
    rd(5'h10);
    @(posedge clk);
    `CHK("irq clr", 1'b0, irq_w)
    $display("test watchdog flag done");
    blow <= 1'b0;
    repeat (IVL * DIV + 20) @(posedge clk);
    rd(5'h0F);
    `CHK("batt ok", 1'b0, q[4])
    blow <= 1'b1;
    repeat (IVL * DIV + 20) @(posedge clk);
    rd(5'h0F);
    `CHK("batt low", 1'b1, q[4])
    $display("test interval done");
    wr(5'h04, 8'h80);
    wr(5'h08, 8'h00);
    sup <= 1'b0;
    @(posedge clk);
    blow <= 1'b0;
    wr(5'h08, 8'h80);
    repeat (IVL * DIV * 3) @(posedge clk);
    rd(5'h0F);
    `CHK("backup batt", 1'b1, q[4])
    power_up(1'b0, 2);
    wr(5'h04, 8'h00);
    wr(5'h01, 8'h00);
    sup <= 1'b0;
    repeat (4) @(posedge clk);
    power_up(1'b0, 3146);
    $display("test later power-up done");
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    `CHK("reset des", 1'b1, des)
    `CHK("reset irq", 1'b0, irq_w)
    $display("test reset done");
    final_report();
  end
endmodule
bind supervisor_defaults_battery_monitor supervisor_chk chk (.clk, .srst,
  .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .supply_above_threshold, .battery_below_low, .watchdog_timeout,
  .shared_open_drain_pin_o, .write_deselect, .irq);
`default_nettype wire
